// ==== aeru_uncorrectable_regs.sv ====
`timescale 1ns/1ps
`include "aeru_params.svh"

// Notes on behaviour
// - Word 100h reads fixed capability code 0001h.
// - Word 102h reads 0000h, end of list.
// - Version nibble conflict resolved by a parameter.
// - Flag bits clear only on written ones.
// - Reserved flag and gate bits read zero.
// - Bit 0 is read only, value undefined.
// - Unsupported request completion sets flag bit 20.
// - End-to-end CRC failure sets flag bit 19.
// - Malformed packet sets flag bit 18.
// - Credit overrun sets flag bit 17.
// - Unmatched completion sets flag bit 16.
// - Completer abort completion sets flag bit 15.
// - Completion timeout sets flag bit 14.
// - Any flow control violation sets bit 13.
// - Poisoning an outgoing packet sets bit 12.
// - Surprise link down sets flag bit 5.
// - Link layer protocol error sets bit 4.
// - Gated errors still flag, never log or message.
// - Gate bits 20..14: one masks, zero passes.
// - Flag and gate registers reset to zero.
// - Gate bits 13, 12, 5, 4 act alike.

module aeru_uncorrectable_regs
	import aeru_pkg::*;
#(
	parameter logic [3:0] CAP_VERSION = 4'h0
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [11:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rd_done,
	output logic cfg_wr_done,
	input wire logic unsupported_request_flag_event,
	input wire logic end_to_end_crc_flag_event,
	input wire logic malformed_packet_flag_event,
	input wire logic receive_overflow_flag_event,
	input wire logic unexpected_completion_flag_event,
	input wire logic completer_abort_flag_event,
	input wire logic completion_timeout_flag_event,
	input wire logic flow_control_protocol_flag_event,
	input wire logic poisoned_packet_flag_event,
	input wire logic surprise_link_down_flag_event,
	input wire logic link_protocol_flag_event,
	output logic [31:0] error_log_vector,
	output logic error_message_req
);

	// The version nibble only ever lives in the low four bits of word 102h.
	if (CAP_VERSION > 4'hF)
	begin : g_bad_version
		$error("CAP_VERSION does not fit in four bits.");
	end

	// Picks a register from a byte address; the low two bits are ignored
	// because configuration accesses are dword aligned with byte enables.
	function automatic aeru_sel_type aeru_decode(input logic [11:0] addr);
		aeru_sel_type sel;
		sel = AERU_SEL_NONE;
		if (addr[11:2] == `AERU_CAP_ID_OFS >> 2)
			sel = AERU_SEL_HEADER;
		else if (addr[11:2] == `AERU_FLAGS_OFS >> 2)
			sel = AERU_SEL_FLAGS;
		else if (addr[11:2] == `AERU_GATE_OFS >> 2)
			sel = AERU_SEL_GATE;
		return sel;
	endfunction : aeru_decode

	aeru_sel_type rd_sel;
	aeru_sel_type wr_sel;
	aeru_word_type events;
	aeru_word_type flags;
	aeru_word_type gate;
	aeru_word_type clear_vec;
	aeru_word_type header_word;
	aeru_word_type cfg_rdata_d;
	logic [31:0] cfg_rdata_q;
	logic cfg_rd_done_q;
	logic cfg_wr_done_q;

	assign rd_sel = aeru_decode(cfg_addr);
	assign wr_sel = aeru_decode(cfg_addr);

	// Error detectors sit on the same clock, so their pulses are used as is.
	always_comb
	begin
		events = 32'h0000_0000;
		events[`AERU_BIT_UNSUP_REQ] = unsupported_request_flag_event;
		events[`AERU_BIT_E2E_CRC] = end_to_end_crc_flag_event;
		events[`AERU_BIT_MALFORMED] = malformed_packet_flag_event;
		events[`AERU_BIT_RX_OVERFLOW] = receive_overflow_flag_event;
		events[`AERU_BIT_UNEXP_CPL] = unexpected_completion_flag_event;
		events[`AERU_BIT_COMPLETER_ABORT_FLAG] = completer_abort_flag_event;
		events[`AERU_BIT_COMPLETION_TIMEOUT_FLAG] = completion_timeout_flag_event;
		events[`AERU_BIT_FC_PROTOCOL] = flow_control_protocol_flag_event;
		events[`AERU_BIT_POISONED] = poisoned_packet_flag_event;
		events[`AERU_BIT_LINK_DOWN] = surprise_link_down_flag_event;
		events[`AERU_BIT_LINK_PROTOCOL] = link_protocol_flag_event;
	end

	// A written one clears, but only in byte lanes that are enabled.
	always_comb
	begin
		clear_vec = 32'h0000_0000;
		if (cfg_wr && wr_sel == AERU_SEL_FLAGS)
		begin
			for (int b = 0; b < 4; b++)
			begin
				if (cfg_be[b])
					clear_vec[8*b +: 8] = cfg_wdata[8*b +: 8];
			end
		end
	end

	// Flags are set regardless of the gate, so masked errors stay visible.
	aeru_flag_bank #(
		.WIDTH(32),
		.IMPL(`AERU_IMPL_MASK)
	) u_flags (
		.clock(clock),
		.resetn(resetn),
		.set_vec(events),
		.clr_vec(clear_vec),
		.flags_q(flags)
	);

	// The gate register decides what is logged and messaged upstream.
	aeru_gate_bank #(
		.IMPL(`AERU_IMPL_MASK)
	) u_gate (
		.clock(clock),
		.resetn(resetn),
		.wr_en(cfg_wr && wr_sel == AERU_SEL_GATE),
		.wr_be(cfg_be),
		.wr_data(cfg_wdata),
		.events(events),
		.gate_q(gate),
		.report_q(error_log_vector),
		.message_q(error_message_req)
	);

	// The header dword is constant: the capability code below, and the end of
	// list marker with the version nibble above. Writes to it are ignored.
	assign header_word = {`AERU_NEXT_VER_VAL | {12'h000, CAP_VERSION},
		`AERU_CAP_ID_VAL};

	// Read data mux; an unmapped address reads zero. Flag and gate bit 0 is driven
	// zero here although software may not rely on its value.
	always_comb
	begin
		case (rd_sel)
			AERU_SEL_HEADER: cfg_rdata_d = header_word;
			AERU_SEL_FLAGS: cfg_rdata_d = flags & `AERU_IMPL_MASK;
			AERU_SEL_GATE: cfg_rdata_d = gate & `AERU_IMPL_MASK;
			AERU_SEL_NONE: cfg_rdata_d = 32'h0000_0000;
			default: cfg_rdata_d = 32'h0000_0000;
		endcase
	end

	// Read data is registered, so it shows the flags as they stood in the
	// cycle of the request, before any event of that same cycle lands.
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			cfg_rdata_q <= 32'h0000_0000;
		else if (cfg_rd)
			cfg_rdata_q <= cfg_rdata_d;
	end

	// Completion strobes for the configuration port, one cycle after a request.
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_rd_done_q <= 1'b0;
			cfg_wr_done_q <= 1'b0;
		end
		else
		begin
			cfg_rd_done_q <= cfg_rd;
			cfg_wr_done_q <= cfg_wr;
		end
	end

	assign cfg_rdata = cfg_rdata_q;
	assign cfg_rd_done = cfg_rd_done_q;
	assign cfg_wr_done = cfg_wr_done_q;

	// Checks on the register behaviour; all in the single clock domain.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	sequence seq_read_header;
		cfg_rd && rd_sel == AERU_SEL_HEADER;
	endsequence

	sequence seq_read_state;
		cfg_rd && (rd_sel == AERU_SEL_FLAGS || rd_sel == AERU_SEL_GATE);
	endsequence

	sequence seq_full_clear;
		cfg_wr && wr_sel == AERU_SEL_FLAGS && cfg_be == 4'hF;
	endsequence

	sequence seq_gate_full_write;
		cfg_wr && wr_sel == AERU_SEL_GATE && cfg_be == 4'hF;
	endsequence

	sequence seq_read_flags;
		cfg_rd && rd_sel == AERU_SEL_FLAGS;
	endsequence

	sequence seq_read_unmapped;
		cfg_rd && rd_sel == AERU_SEL_NONE;
	endsequence

	// Header reads return the fixed capability code.
	AST_CAP_ID_READ: assert property (
		seq_read_header |=> cfg_rd_done && cfg_rdata[15:0] == 16'h0001)
		else $error("Capability code read back wrong.");

	// The upper header word carries no next pointer, only the version nibble.
	AST_NEXT_WORD_READ: assert property (
		seq_read_header |=> cfg_rdata[31:20] == 12'h000
			&& cfg_rdata[19:16] == CAP_VERSION)
		else $error("Next pointer word read back wrong.");

	// Reserved positions of both state registers read as zero.
	AST_RESERVED_ZERO: assert property (
		seq_read_state |=> (cfg_rdata & ~`AERU_IMPL_MASK) == 32'h0000_0000)
		else $error("Reserved bits read nonzero.");

	// A written one with no event clears the flag in the next cycle.
	AST_ONE_CLEARS: assert property (
		seq_full_clear ##0 (cfg_wdata & ~events & `AERU_IMPL_MASK) != 32'h0000_0000
		|=> (flags & $past(cfg_wdata & ~events & `AERU_IMPL_MASK)) == 32'h0000_0000)
		else $error("Written one did not clear the flag.");

	// A written zero leaves every set flag as it was.
	AST_ZERO_KEEPS: assert property (
		cfg_wr && wr_sel == AERU_SEL_FLAGS
		|=> (flags & $past(flags & ~cfg_wdata)) == $past(flags & ~cfg_wdata))
		else $error("Written zero disturbed a flag.");

	// Every detected error is flagged in the next cycle, gated or not.
	AST_EVENT_FLAGS: assert property (
		events != 32'h0000_0000 |=> (flags & $past(events)) == $past(events))
		else $error("Detected error was not flagged.");

	// An error that meets a clear of its own flag still ends up set.
	AST_SET_BEATS_CLEAR: assert property (
		(events & clear_vec) != 32'h0000_0000
		|=> (flags & $past(events & clear_vec)) == $past(events & clear_vec))
		else $error("Clear won over a same-cycle error.");

	// A gated error is neither logged nor messaged in the cycle after it.
	AST_GATED_SILENT: assert property (
		(events & gate) != 32'h0000_0000 && (events & ~gate) == 32'h0000_0000
		|=> error_log_vector == 32'h0000_0000 && !error_message_req)
		else $error("Gated error was reported.");

	// An ungated error is logged at its own position with a message request.
	AST_UNGATED_REPORTS: assert property (
		(events & ~gate) != 32'h0000_0000
		|=> error_message_req
			&& (error_log_vector & $past(events & ~gate)) == $past(events & ~gate))
		else $error("Ungated error was not reported.");

	// Gate bits for the lower errors store like the rest and read back.
	AST_LOW_GATE_STORES: assert property (
		cfg_wr && wr_sel == AERU_SEL_GATE && cfg_be[0] && cfg_be[1]
		|=> gate[13:12] == $past(cfg_wdata[13:12]) && gate[5:4] == $past(cfg_wdata[5:4]))
		else $error("Lower gate bits did not store.");

	// Gate writes only change the bits that the register implements.
	AST_GATE_RESERVED: assert property (
		(gate & ~`AERU_IMPL_MASK) == 32'h0000_0000)
		else $error("Gate register holds a reserved bit.");

	// Every read is answered in the next cycle.
	AST_RD_DONE: assert property (
		cfg_rd |=> cfg_rd_done)
		else $error("Read was not answered.");

	// Every write is answered in the next cycle.
	AST_WR_DONE: assert property (
		cfg_wr |=> cfg_wr_done)
		else $error("Write was not answered.");

	// A flag read returns the flags as they stood in the cycle of the request.
	AST_FLAGS_READ: assert property (
		seq_read_flags |=> cfg_rdata == $past(flags))
		else $error("Flag read returned the wrong value.");

	// Unmapped addresses read as zero.
	AST_UNMAPPED_ZERO: assert property (
		seq_read_unmapped |=> cfg_rdata == 32'h0000_0000)
		else $error("Unmapped read returned nonzero data.");

	// Reserved flag positions never hold a one.
	AST_FLAGS_RESERVED: assert property (
		(flags & ~`AERU_IMPL_MASK) == 32'h0000_0000)
		else $error("Flag register holds a reserved bit.");

	// With no error and no written one, the flags stay as they are.
	AST_FLAG_HOLD: assert property (
		events == 32'h0000_0000 && clear_vec == 32'h0000_0000 |=> $stable(flags))
		else $error("Flags changed with no cause.");

	// A flag only falls where software wrote a one to it.
	AST_FALL_NEEDS_ONE: assert property (
		($past(flags) & ~flags & ~$past(clear_vec)) == 32'h0000_0000)
		else $error("Flag fell without a written one.");

	// A flag only rises where its detector fired in the cycle before.
	AST_RISE_NEEDS_EVENT: assert property (
		(flags & ~$past(flags) & ~$past(events)) == 32'h0000_0000)
		else $error("Flag rose with no error behind it.");

	// A full gate write stores exactly the implemented bits.
	AST_GATE_FULL_WRITE: assert property (
		seq_gate_full_write |=> gate == ($past(cfg_wdata) & `AERU_IMPL_MASK))
		else $error("Gate write stored the wrong value.");

	// A log bit never appears at a position that was gated when the error came.
	AST_GATED_BIT_SILENT: assert property (
		(error_log_vector & $past(gate)) == 32'h0000_0000)
		else $error("Gated position was logged.");

	// The log only names errors detected in the cycle before.
	AST_LOG_FROM_EVENTS: assert property (
		(error_log_vector & ~$past(events)) == 32'h0000_0000)
		else $error("Log names an error that was not detected.");

	// The upstream message request goes with a nonempty log, never alone.
	AST_MESSAGE_WITH_LOG: assert property (
		error_message_req == (error_log_vector != 32'h0000_0000))
		else $error("Message request and log disagree.");

endmodule : aeru_uncorrectable_regs

// ==== aeru_params.svh ====
`ifndef AERU_PARAMS_SVH
`define AERU_PARAMS_SVH

// Byte offsets of the capability words in configuration space.
`define AERU_CAP_ID_OFS 12'h100
`define AERU_NEXT_VER_OFS 12'h102
`define AERU_FLAGS_OFS 12'h104
`define AERU_GATE_OFS 12'h108

// Fixed header values and register reset values.
`define AERU_CAP_ID_VAL 16'h0001
`define AERU_NEXT_VER_VAL 16'h0000
`define AERU_FLAGS_RST 32'h0000_0000
`define AERU_GATE_RST 32'h0000_0000

// Bit positions of the error fields in the flag and gate registers.
`define AERU_BIT_UNSUP_REQ 20
`define AERU_BIT_E2E_CRC 19
`define AERU_BIT_MALFORMED 18
`define AERU_BIT_RX_OVERFLOW 17
`define AERU_BIT_UNEXP_CPL 16
`define AERU_BIT_COMPLETER_ABORT_FLAG 15
`define AERU_BIT_COMPLETION_TIMEOUT_FLAG 14
`define AERU_BIT_FC_PROTOCOL 13
`define AERU_BIT_POISONED 12
`define AERU_BIT_LINK_DOWN 5
`define AERU_BIT_LINK_PROTOCOL 4

// Bits that hold state; every other bit reads as zero.
`define AERU_IMPL_MASK 32'h001F_F030

`endif

// ==== aeru_pkg.sv ====
package aeru_pkg;

	// One configuration dword.
	typedef logic [31:0] aeru_word_type;

	// Which register a configuration access selects.
	typedef enum logic [1:0] {
		AERU_SEL_HEADER,
		AERU_SEL_FLAGS,
		AERU_SEL_GATE,
		AERU_SEL_NONE
	} aeru_sel_type;

endpackage : aeru_pkg

// ==== aeru_flag_bank.sv ====
`timescale 1ns/1ps
`include "aeru_params.svh"

module aeru_flag_bank
	import aeru_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter logic [31:0] IMPL = `AERU_IMPL_MASK
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] set_vec,
	input wire logic [WIDTH-1:0] clr_vec,
	output logic [WIDTH-1:0] flags_q
);

	// The bank only serves one configuration dword.
	if (WIDTH != 32)
	begin : g_bad_width
		$error("aeru_flag_bank supports WIDTH of 32 only.");
	end

	// Each implemented bit is a sticky flag; the set term is tested before the clear so
	// that an error arriving with a clear of the same bit is never lost.
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		if (IMPL[i])
		begin : g_impl
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
					flags_q[i] <= 1'b0;
				else if (set_vec[i])
					flags_q[i] <= 1'b1;
				else if (clr_vec[i])
					flags_q[i] <= 1'b0;
			end
		end
		else
		begin : g_rsvd
			assign flags_q[i] = 1'b0;
		end
	end

endmodule : aeru_flag_bank

// ==== aeru_gate_bank.sv ====
`timescale 1ns/1ps
`include "aeru_params.svh"

module aeru_gate_bank
	import aeru_pkg::*;
#(
	parameter logic [31:0] IMPL = `AERU_IMPL_MASK
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic wr_en,
	input wire logic [3:0] wr_be,
	input wire aeru_word_type wr_data,
	input wire aeru_word_type events,
	output aeru_word_type gate_q,
	output aeru_word_type report_q,
	output logic message_q
);

	// Reset value held as a word so that each lane takes its own byte of it.
	localparam aeru_word_type GATE_RST = `AERU_GATE_RST;

	// Gate bits are written per byte lane; reserved positions never store.
	for (genvar b = 0; b < 4; b++)
	begin : g_lane
		always_ff @(posedge clock or negedge resetn)
		begin
			if (!resetn)
				gate_q[8*b +: 8] <= GATE_RST[8*b +: 8];
			else if (wr_en && wr_be[b])
				gate_q[8*b +: 8] <= wr_data[8*b +: 8] & IMPL[8*b +: 8];
		end
	end

	// Only unmasked errors reach the log and the upstream message request.
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			report_q <= 32'h0000_0000;
			message_q <= 1'b0;
		end
		else
		begin
			report_q <= events & ~gate_q & IMPL;
			message_q <= |(events & ~gate_q & IMPL);
		end
	end

endmodule : aeru_gate_bank

// ==== aeru_error_source.sv ====
`timescale 1ns/1ps

// Stand-in for the port's error detectors. Each set bit of fire raises the event input at
// that flag position; fire bits with no detector behind them are simply ignored.
module aeru_error_source
(
	input wire logic [31:0] fire,
	output logic unsupported_request_flag_event,
	output logic end_to_end_crc_flag_event,
	output logic malformed_packet_flag_event,
	output logic receive_overflow_flag_event,
	output logic unexpected_completion_flag_event,
	output logic completer_abort_flag_event,
	output logic completion_timeout_flag_event,
	output logic flow_control_protocol_flag_event,
	output logic poisoned_packet_flag_event,
	output logic surprise_link_down_flag_event,
	output logic link_protocol_flag_event
);
	// Detectors answer at once; the bench holds fire for exactly one cycle per error,
	// so a slower detector would only move the pulse, never stretch it.
	assign unsupported_request_flag_event = fire[20];
	assign end_to_end_crc_flag_event = fire[19];
	assign malformed_packet_flag_event = fire[18];
	assign receive_overflow_flag_event = fire[17];
	assign unexpected_completion_flag_event = fire[16];
	assign completer_abort_flag_event = fire[15];
	assign completion_timeout_flag_event = fire[14];
	assign flow_control_protocol_flag_event = fire[13];
	assign poisoned_packet_flag_event = fire[12];
	assign surprise_link_down_flag_event = fire[5];
	assign link_protocol_flag_event = fire[4];
endmodule : aeru_error_source

// ==== test_aeru_uncorrectable_regs.sv ====
`timescale 1ns/1ps
`include "aeru_params.svh"

module test_aeru_uncorrectable_regs import aeru_pkg::*;;
	typedef struct {aeru_word_type ev; aeru_word_type gate; aeru_word_type log;} aeru_row_type;
	logic clock, resetn, cfg_rd, cfg_wr, cfg_rd_done, cfg_wr_done, error_message_req;
	logic [11:0] cfg_addr;
	logic [3:0] cfg_be;
	aeru_word_type cfg_wdata, cfg_rdata, error_log_vector, fire;
	logic unsupported_request_flag_event, end_to_end_crc_flag_event;
	logic malformed_packet_flag_event, receive_overflow_flag_event;
	logic unexpected_completion_flag_event, completer_abort_flag_event;
	logic completion_timeout_flag_event, flow_control_protocol_flag_event;
	logic poisoned_packet_flag_event, surprise_link_down_flag_event, link_protocol_flag_event;
	int err_total = 0;
	int cmp_count = 0;
	int cycles = 0;
	int bits [11] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 5, 4};
	aeru_row_type rows [15];

	// Design and the detectors that feed it, joined by matching names.
	aeru_uncorrectable_regs aeru_uncorrectable_regs_i (
		.clock(clock),
		.resetn(resetn),
		.cfg_rd(cfg_rd),
		.cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr),
		.cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata),
		.cfg_rd_done(cfg_rd_done),
		.cfg_wr_done(cfg_wr_done),
		.unsupported_request_flag_event(unsupported_request_flag_event),
		.end_to_end_crc_flag_event(end_to_end_crc_flag_event),
		.malformed_packet_flag_event(malformed_packet_flag_event),
		.receive_overflow_flag_event(receive_overflow_flag_event),
		.unexpected_completion_flag_event(unexpected_completion_flag_event),
		.completer_abort_flag_event(completer_abort_flag_event),
		.completion_timeout_flag_event(completion_timeout_flag_event),
		.flow_control_protocol_flag_event(flow_control_protocol_flag_event),
		.poisoned_packet_flag_event(poisoned_packet_flag_event),
		.surprise_link_down_flag_event(surprise_link_down_flag_event),
		.link_protocol_flag_event(link_protocol_flag_event),
		.error_log_vector(error_log_vector),
		.error_message_req(error_message_req)
	);
	aeru_error_source aeru_error_source_i (
		.fire(fire),
		.unsupported_request_flag_event(unsupported_request_flag_event),
		.end_to_end_crc_flag_event(end_to_end_crc_flag_event),
		.malformed_packet_flag_event(malformed_packet_flag_event),
		.receive_overflow_flag_event(receive_overflow_flag_event),
		.unexpected_completion_flag_event(unexpected_completion_flag_event),
		.completer_abort_flag_event(completer_abort_flag_event),
		.completion_timeout_flag_event(completion_timeout_flag_event),
		.flow_control_protocol_flag_event(flow_control_protocol_flag_event),
		.poisoned_packet_flag_event(poisoned_packet_flag_event),
		.surprise_link_down_flag_event(surprise_link_down_flag_event),
		.link_protocol_flag_event(link_protocol_flag_event)
	);

	// Free-running 200 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// A hang is cut short well past the fewer than 200 cycles the tests need.
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_total++;
			test_done();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	// Word compare; bits outside care are not judged, since flag bit 0 is undefined.
	task automatic chk(input aeru_word_type got, input aeru_word_type exp,
		input aeru_word_type care);
		cmp_count++;
		if (((got ^ exp) & care) !== 32'h0000_0000)
		begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Single-bit compare for strobes.
	task automatic chk_bit(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp}, 32'h0000_0001);
	endtask : chk_bit

	// Read: raised at a falling edge, answer sampled one cycle later. The idle
	// cycle after it keeps the next request from raising the strobe that this
	// one lowers in the same time step, and shows that the data hold.
	task automatic rd(input logic [11:0] addr, input aeru_word_type exp);
		cfg_rd = 1'b1;
		cfg_addr = addr;
		@(negedge clock);
		cfg_rd = 1'b0;
		chk_bit(cfg_rd_done, 1'b1);
		chk(cfg_rdata, exp, (addr == 12'h100) ? 32'hFFFF_FFFF : 32'hFFFF_FFFE);
		@(negedge clock);
		chk_bit(cfg_rd_done, 1'b0);
		chk(cfg_rdata, exp, (addr == 12'h100) ? 32'hFFFF_FFFF : 32'hFFFF_FFFE);
	endtask : rd

	// Write: raised at a falling edge, completion sampled one cycle later.
	task automatic wr(input logic [11:0] addr, input logic [3:0] be, input aeru_word_type data);
		cfg_wr = 1'b1;
		cfg_addr = addr;
		cfg_be = be;
		cfg_wdata = data;
		@(negedge clock);
		cfg_wr = 1'b0;
		chk_bit(cfg_wr_done, 1'b1);
		@(negedge clock);
		chk_bit(cfg_wr_done, 1'b0);
	endtask : wr

	// Main sequence: reset, register map, error rows, then the awkward cases.
	initial
	begin
		{cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata, fire} = '0;
		resetn = 1'b0;
		rows[0] = '{32'h001F_F030, 32'h0000_0000, 32'h001F_F030};
		rows[1] = '{32'h001F_F030, 32'h001F_F030, 32'h0000_0000};
		rows[2] = '{32'h001F_F030, 32'h000A_A020, 32'h0015_5010};
		rows[3] = '{32'h001F_F030, 32'h0015_5010, 32'h000A_A020};
		foreach (bits[i])
			rows[i + 4] = '{32'h1 << bits[i], 32'h001F_F030 & ~(32'h1 << bits[i]), 32'h1 << bits[i]};
		repeat (12) @(negedge clock);
		resetn = 1'b1;
		rd(`AERU_CAP_ID_OFS, 32'h0000_0001);
		rd(`AERU_FLAGS_OFS, 32'h0000_0000);
		rd(`AERU_GATE_OFS, 32'h0000_0000);
		wr(`AERU_GATE_OFS, 4'hF, 32'hFFFF_FFFF);
		rd(`AERU_GATE_OFS, 32'h001F_F030);
		wr(`AERU_GATE_OFS, 4'h4, 32'h0000_0000);
		rd(`AERU_GATE_OFS, 32'h0000_F030);
		wr(`AERU_CAP_ID_OFS, 4'hF, 32'hFFFF_FFFF);
		rd(`AERU_CAP_ID_OFS, 32'h0000_0001);
		rd(12'h200, 32'h0000_0000);
		// Each row: gate, one cycle of errors, log and message, flags, then clear.
		foreach (rows[i])
		begin
			wr(`AERU_GATE_OFS, 4'hF, rows[i].gate);
			fire = rows[i].ev;
			@(negedge clock);
			fire = '0;
			chk(error_log_vector, rows[i].log, 32'hFFFF_FFFF);
			chk_bit(error_message_req, |rows[i].log);
			rd(`AERU_FLAGS_OFS, rows[i].ev);
			wr(`AERU_FLAGS_OFS, 4'hF, rows[i].ev);
			rd(`AERU_FLAGS_OFS, 32'h0000_0000);
		end
		// A detection in the very cycle of its clear must survive. The write is
		// driven by hand so that the error stands at that one edge only.
		fire = 32'h0004_0000;
		cfg_wr = 1'b1;
		cfg_addr = `AERU_FLAGS_OFS;
		cfg_be = 4'hF;
		cfg_wdata = 32'h0004_0000;
		@(negedge clock);
		fire = '0;
		cfg_wr = 1'b0;
		chk_bit(cfg_wr_done, 1'b1);
		@(negedge clock);
		rd(`AERU_FLAGS_OFS, 32'h0004_0000);
		wr(`AERU_FLAGS_OFS, 4'hF, 32'h0000_0000);
		rd(`AERU_FLAGS_OFS, 32'h0004_0000);
		// A reset in mid-run must wipe both flags and gate.
		wr(`AERU_GATE_OFS, 4'hF, 32'hFFFF_FFFF);
		resetn = 1'b0;
		repeat (3) @(negedge clock);
		resetn = 1'b1;
		rd(`AERU_FLAGS_OFS, 32'h0000_0000);
		rd(`AERU_GATE_OFS, 32'h0000_0000);
		test_done();
	end
endmodule : test_aeru_uncorrectable_regs
